// file: design/slave_port_consts.vh
/*
 * constants of the parallel slave port: register offsets, field positions,
 * reset values and the all-inputs control direction code.
 * assumes an 8-bit register bus with a 3-bit address.
 */
`ifndef SLAVE_PORT_CONSTS_VH
`define SLAVE_PORT_CONSTS_VH

// ==========================================================================
// register offsets
`define OFS_CONTROL        3'h0
`define OFS_DATA           3'h1
`define OFS_REQUEST        3'h2
`define OFS_CTRL_DIR       3'h3
`define OFS_DATA_DIR       3'h4

// ==========================================================================
// control register fields
`define BIT_INPUT_FULL     7
`define BIT_OUTPUT_FULL    6
`define BIT_OVERFLOW       5
`define BIT_SELECT         4

// ==========================================================================
// request register fields
`define BIT_PORT_INT       7

// ==========================================================================
// reset values and the all-inputs control direction code
`define RST_CTRL_DIR       3'h7
`define RST_DATA_DIR       8'hff
`define RST_BYTE           8'h00
`define CTRL_DIR_INPUTS    3'h7

`endif

// file: design/pin_sync.v
/*
 * three-stage input synchroniser with agreement filter.
 * assumes inputs are asynchronous to CLK; output changes only once
 * the second and third stages agree.
 */
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             CLK,
	input  wire             RESET,
	input  wire [WIDTH-1:0] D,
	output wire [WIDTH-1:0] Q
);

	reg  [WIDTH-1:0] s1_q;
	reg  [WIDTH-1:0] s2_q;
	reg  [WIDTH-1:0] s3_q;
	reg  [WIDTH-1:0] level_q;
	wire [WIDTH-1:0] level_d;
	wire [WIDTH-1:0] agree;

	// ======================================================================
	// first stage is read only by the second
	assign agree   = ~(s2_q ^ s3_q);
	assign level_d = (agree & s3_q) | (~agree & level_q);

	always @(posedge CLK) begin
		if (RESET) begin
			s1_q    <= INIT;
			s2_q    <= INIT;
			s3_q    <= INIT;
			level_q <= INIT;
		end else begin
			s1_q    <= D;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end

	assign Q = level_q;

endmodule // pin_sync

// file: design/parallel_slave_port.v
/*
 * parallel slave port: 8-bit data port usable as a latch for an external
 * processor, with input-full, output-full, overflow and interrupt flags.
 * assumes a one-clock register bus (read data one cycle after the read
 * strobe) and asynchronous strobes from the external processor.
 */
// Chosen here: the address-and-strobe port and the address map.
`include "slave_port_consts.vh"

module parallel_slave_port #(
	parameter DATA_W = 8
) (
	input  wire              CLK,
	input  wire              RESET,
	input  wire [2:0]        ADDR,
	input  wire [7:0]        WDATA,
	input  wire              WR_STB,
	input  wire              RD_STB,
	output wire [7:0]        RDATA,
	input  wire              MCU_MODE,
	input  wire              RD_N,
	input  wire              WR_N,
	input  wire              CS_N,
	input  wire [DATA_W-1:0] DATA_PORT_PINS_IN,
	output wire [DATA_W-1:0] DATA_PORT_PINS_OUT,
	output wire [DATA_W-1:0] DATA_PORT_PINS_OE,
	output wire              PORT_INTERRUPT_FLAG,
	output wire              SLAVE_PORT_ACTIVE
);

	reg  [7:0]        rdata_q;
	reg               slave_port_select_q;
	reg               input_full_flag_q;
	reg               output_full_flag_q;
	reg               input_overflow_flag_q;
	reg               port_interrupt_flag_q;
	reg  [2:0]        control_pin_direction_q;
	reg  [DATA_W-1:0] data_dir_q;
	reg  [DATA_W-1:0] out_latch_q;
	reg  [DATA_W-1:0] in_latch_q;
	reg               wr_act_q;
	reg               rd_act_q;
	wire [2:0]        strobes;
	wire [DATA_W-1:0] pins;
	wire              enabled;
	wire              wr_act;
	wire              rd_act;
	wire              wr_end;
	wire              rd_start;
	wire              rd_end;
	wire              cpu_wr_ctrl;
	wire              cpu_wr_data;
	wire              cpu_wr_req;
	wire              cpu_wr_cdir;
	wire              cpu_wr_ddir;
	wire              cpu_rd_data;

	// ======================================================================
	// synchronisers
	pin_sync #(
		.WIDTH (3),
		.INIT  (3'h7)
	) u_strobe_sync (
		.CLK   (CLK),
		.RESET (RESET),
		.D     ({CS_N, WR_N, RD_N}),
		.Q     (strobes)
	);

	pin_sync #(
		.WIDTH (DATA_W),
		.INIT  ({DATA_W{1'b0}})
	) u_data_sync (
		.CLK   (CLK),
		.RESET (RESET),
		.D     (DATA_PORT_PINS_IN),
		.Q    (pins)
	);

	// ======================================================================
	// mode and access detection
	assign enabled = slave_port_select_q & MCU_MODE
		& (control_pin_direction_q == `CTRL_DIR_INPUTS);
	assign wr_act   = enabled & ~strobes[2] & ~strobes[1];
	assign rd_act   = enabled & ~strobes[2] & ~strobes[0];
	// an end is only counted while the port stays enabled: dropping the mode
	// in mid-access must not look like a finished transfer
	assign wr_end   = enabled & wr_act_q & ~wr_act;
	assign rd_start = rd_act & ~rd_act_q;
	assign rd_end   = enabled & rd_act_q & ~rd_act;

	// ======================================================================
	// register decode
	function reg_hit;
		input       stb;
		input [2:0] addr;
		input [2:0] ofs;
		begin
			reg_hit = stb & (addr == ofs);
		end
	endfunction

	assign cpu_wr_ctrl = reg_hit(WR_STB, ADDR, `OFS_CONTROL);
	assign cpu_wr_data = reg_hit(WR_STB, ADDR, `OFS_DATA);
	assign cpu_wr_req  = reg_hit(WR_STB, ADDR, `OFS_REQUEST);
	assign cpu_wr_cdir = reg_hit(WR_STB, ADDR, `OFS_CTRL_DIR);
	assign cpu_wr_ddir = reg_hit(WR_STB, ADDR, `OFS_DATA_DIR);
	assign cpu_rd_data = reg_hit(RD_STB, ADDR, `OFS_DATA);

	always @(posedge CLK) begin
		if (RESET) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
		end
	end

	// ======================================================================
	// configuration registers
	always @(posedge CLK) begin
		if (RESET) begin
			slave_port_select_q     <= 1'b0;
			control_pin_direction_q <= `RST_CTRL_DIR;
			data_dir_q              <= `RST_DATA_DIR;
			out_latch_q             <= `RST_BYTE;
		end else begin
			if (cpu_wr_ctrl) begin
				slave_port_select_q <= WDATA[`BIT_SELECT];
			end
			if (cpu_wr_cdir) begin
				control_pin_direction_q <= WDATA[2:0];
			end
			if (cpu_wr_ddir) begin
				data_dir_q <= WDATA[DATA_W-1:0];
			end
			if (cpu_wr_data) begin
				out_latch_q <= WDATA[DATA_W-1:0];
			end
		end
	end

	// ======================================================================
	// data capture and status flags; hardware set wins over software clear
	always @(posedge CLK) begin
		if (RESET) begin
			in_latch_q            <= `RST_BYTE;
			input_full_flag_q     <= 1'b0;
			output_full_flag_q    <= 1'b0;
			input_overflow_flag_q <= 1'b0;
			port_interrupt_flag_q <= 1'b0;
		end else begin
			// data is sampled while the write is still low, so the data
			// synchroniser has settled by the time the strobe edge is seen
			if (wr_act) begin
				in_latch_q <= pins;
			end
			if (wr_end) begin
				input_full_flag_q <= 1'b1;
			end else if (cpu_rd_data) begin
				input_full_flag_q <= 1'b0;
			end
			if (wr_end && input_full_flag_q && !cpu_rd_data) begin
				input_overflow_flag_q <= 1'b1;
			end else if (cpu_wr_ctrl && !WDATA[`BIT_OVERFLOW]) begin
				input_overflow_flag_q <= 1'b0;
			end
			if (cpu_wr_data && !rd_act) begin
				output_full_flag_q <= 1'b1;
			end else if (rd_start) begin
				output_full_flag_q <= 1'b0;
			end
			if (wr_end || rd_end) begin
				port_interrupt_flag_q <= 1'b1;
			end else if (cpu_wr_req && !WDATA[`BIT_PORT_INT]) begin
				port_interrupt_flag_q <= 1'b0;
			end
		end
	end

	// ======================================================================
	// pin drive: while enabled, latch on pins during external read and released otherwise; when not enabled, general purpose
	assign DATA_PORT_PINS_OUT = out_latch_q;
	assign DATA_PORT_PINS_OE  = enabled ? {DATA_W{rd_act_q}} : ~data_dir_q;

	// ======================================================================
	// register read-back
	always @(posedge CLK) begin
		if (RESET) begin
			rdata_q <= `RST_BYTE;
		end else if (RD_STB) begin
			if (ADDR == `OFS_CONTROL) begin
				rdata_q <= {input_full_flag_q, output_full_flag_q,
					input_overflow_flag_q, slave_port_select_q, 4'h0};
			end else if (ADDR == `OFS_DATA) begin
				rdata_q <= enabled ? in_latch_q : pins;
			end else if (ADDR == `OFS_REQUEST) begin
				rdata_q <= {port_interrupt_flag_q, 7'h00};
			end else if (ADDR == `OFS_CTRL_DIR) begin
				rdata_q <= {5'h00, control_pin_direction_q};
			end else if (ADDR == `OFS_DATA_DIR) begin
				rdata_q <= data_dir_q;
			end else begin
				rdata_q <= `RST_BYTE;
			end
		end else begin
			rdata_q <= `RST_BYTE;
		end
	end

	assign RDATA               = rdata_q;
	assign PORT_INTERRUPT_FLAG = port_interrupt_flag_q;
	assign SLAVE_PORT_ACTIVE   = enabled;

endmodule // parallel_slave_port

// file: tb/psp_assertions.sv
/* checker: port relations of parallel_slave_port.
   assumes bind by port name, one clock, sync reset. */
`include "slave_port_consts.vh"
module psp_checker (
	input wire logic       CLK,
	input wire logic       RESET,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR_STB,
	input wire logic       RD_STB,
	input wire logic [7:0] RDATA,
	input wire logic       MCU_MODE,
	input wire logic       RD_N,
	input wire logic       WR_N,
	input wire logic       CS_N,
	input wire logic [7:0] DATA_PORT_PINS_IN,
	input wire logic [7:0] DATA_PORT_PINS_OUT,
	input wire logic [7:0] DATA_PORT_PINS_OE,
	input wire logic       PORT_INTERRUPT_FLAG,
	input wire logic       SLAVE_PORT_ACTIVE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// ==========
	// properties
	a_mode_gate: assert property (!MCU_MODE |=> !$rose(PORT_INTERRUPT_FLAG))
		else $error("flag raised outside mcu mode");
	a_ctrl_low: assert property (RD_STB && ADDR == `OFS_CONTROL |=> RDATA[3:0] == 4'h0)
		else $error("control low bits set");
	a_hole_zero: assert property (RD_STB && ADDR > 3'h4 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_oe_cause: assert property (
		SLAVE_PORT_ACTIVE && $rose(DATA_PORT_PINS_OE[0]) |-> $past(!(CS_N | RD_N), 2))
		else $error("pins driven without read");
	a_oe_whole: assert property (
		SLAVE_PORT_ACTIVE && DATA_PORT_PINS_OE != 8'h00 |-> DATA_PORT_PINS_OE == 8'hff)
		else $error("partial drive");
	a_oe_release: assert property (
		(SLAVE_PORT_ACTIVE && (CS_N || RD_N)) [*8] |-> DATA_PORT_PINS_OE == 8'h00)
		else $error("pins held after read");
	a_cpu_visible: assert property (
		DATA_PORT_PINS_OE == 8'hff && WR_STB && ADDR == `OFS_DATA |=> DATA_PORT_PINS_OUT == $past(WDATA))
		else $error("cpu write not on pins");
	a_flag_cause: assert property (
		$rose(PORT_INTERRUPT_FLAG) |-> $past(SLAVE_PORT_ACTIVE) && $past(CS_N || (WR_N && RD_N), 2))
		else $error("flag without access end");
endmodule // psp_checker
bind parallel_slave_port psp_checker chk (.*);

// file: tb/ext_cpu.sv
/* far-side processor on the strobes and data pins.
   assumes the bench calls access; pins carry no pull. */
module ext_cpu (
	input  wire logic       CLK,
	input  wire logic [7:0] DATA_PORT_PINS_OUT,
	input  wire logic [7:0] DATA_PORT_PINS_OE,
	output logic            RD_N = 1'b1,
	output logic            WR_N = 1'b1,
	output logic            CS_N = 1'b1,
	output wire logic [7:0] DATA_PORT_PINS_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dq = 8'h00;
	logic       den = 1'b0;
	// ==========
	// bus: a line driven by neither side shows the inverse of dq, never a held copy
	assign DATA_PORT_PINS_IN = (DATA_PORT_PINS_OE & DATA_PORT_PINS_OUT) | (~DATA_PORT_PINS_OE & (den ? dq : ~dq));
	task automatic access(input logic w, input logic [7:0] d, input int len, output logic [7:0] q);
		@(posedge CLK);
		dq <= d;
		den <= w;
		CS_N <= 1'b0;
		RD_N <= w;
		WR_N <= !w;
		repeat (len) @(posedge CLK);
		q = DATA_PORT_PINS_IN;
		RD_N <= 1'b1;
		WR_N <= 1'b1;
		CS_N <= 1'b1;
		repeat (4) @(posedge CLK);
		den <= 1'b0;
		repeat (8) @(posedge CLK);
	endtask
endmodule // ext_cpu

// file: tb/tb.sv
/* self-checking bench for the parallel slave port.
   assumes the checker binds itself and ext_cpu plays the far side. */
`include "slave_port_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
	logic       CLK = 1'b0;
	logic       RESET = 1'b1;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] WDATA = 8'h00;
	logic       WR_STB = 1'b0;
	logic       RD_STB = 1'b0;
	logic       MCU_MODE = 1'b1;
	logic [7:0] b, c;
	int         fails = 0;
	int         checked = 0;
	wire  [7:0] RDATA, DATA_PORT_PINS_IN, DATA_PORT_PINS_OUT, DATA_PORT_PINS_OE;
	wire        RD_N, WR_N, CS_N, PORT_INTERRUPT_FLAG, SLAVE_PORT_ACTIVE;
	parallel_slave_port uut (.*);
	ext_cpu cpu (.*);
	initial forever #2 CLK = ~CLK;
	// ==========
	// register bus
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR_STB <= 1'b1;
		@(posedge CLK);
		WR_STB <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLK);
		RD_STB <= 1'b0;
		#1 `CHK("rdata", e, RDATA)
	endtask
	function automatic logic [7:0] ctl(input logic i, o, v);
		return {i, o, v, 1'b1, 4'h0};
	endfunction
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========
	// scenarios
	initial begin
		void'($urandom(32'h85d4));
		repeat (16) @(posedge CLK);
		RESET <= 1'b0;
		cpu.access(1'b1, 8'h3c, 8, b);
		`CHK("flag", 1'b0, PORT_INTERRUPT_FLAG)
		rd(`OFS_CONTROL, 8'h00);
		rd(`OFS_REQUEST, 8'h00);
		rd(`OFS_CTRL_DIR, 8'h07);
		rd(3'h6, 8'h00);
		wr(`OFS_CONTROL, 8'hdf);
		rd(`OFS_CONTROL, ctl(0, 0, 0));
		wr(`OFS_CTRL_DIR, 8'h03);
		#1 `CHK("active", 1'b0, SLAVE_PORT_ACTIVE)
		wr(`OFS_CTRL_DIR, 8'h07);
		#1 `CHK("active", 1'b1, SLAVE_PORT_ACTIVE)
		for (int k = 0; k < 6; k++) begin
			c = 8'($urandom);
			cpu.access(1'b1, c, 6 + $urandom % 12, b);
			`CHK("flag", 1'b1, PORT_INTERRUPT_FLAG)
			rd(`OFS_CONTROL, ctl(1, 0, 0));
			rd(`OFS_DATA, c);
			rd(`OFS_CONTROL, ctl(0, 0, 0));
			wr(`OFS_REQUEST, 8'h00);
		end
		cpu.access(1'b1, 8'h5a, 6, b);
		cpu.access(1'b1, 8'ha5, 20, b);
		rd(`OFS_CONTROL, ctl(1, 0, 1));
		rd(`OFS_DATA, 8'ha5);
		rd(`OFS_CONTROL, ctl(0, 0, 1));
		wr(`OFS_CONTROL, 8'h10);
		rd(`OFS_CONTROL, ctl(0, 0, 0));
		wr(`OFS_REQUEST, 8'h00);
		c = 8'($urandom);
		wr(`OFS_DATA, c);
		rd(`OFS_CONTROL, ctl(0, 1, 0));
		cpu.access(1'b0, 8'h00, 8, b);
		`CHK("pins", c, b)
		`CHK("flag", 1'b1, PORT_INTERRUPT_FLAG)
		`CHK("oe", 8'h00, DATA_PORT_PINS_OE)
		rd(`OFS_CONTROL, ctl(0, 0, 0));
		c = 8'($urandom);
		fork
			cpu.access(1'b0, 8'h00, 20, b);
			begin
				repeat (12) @(posedge CLK);
				wr(`OFS_DATA, c);
			end
		join
		`CHK("pins", c, b)
		rd(`OFS_CONTROL, ctl(0, 0, 0));
		wr(`OFS_REQUEST, 8'h00);
		MCU_MODE <= 1'b0;
		cpu.access(1'b1, 8'hc3, 8, b);
		`CHK("flag", 1'b0, PORT_INTERRUPT_FLAG)
		rd(`OFS_CONTROL, ctl(0, 0, 0));
		wr(`OFS_DATA_DIR, 8'h0f);
		#1 `CHK("oe", 8'hf0, DATA_PORT_PINS_OE)
		rd(`OFS_DATA_DIR, 8'h0f);
		give_verdict();
	end
endmodule // tb
